// ### sim/dev_model.sv
`timescale 1ns/1ns
// Display device register file with a four-phase write acknowledge
module dev_model (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] dev_addr_in,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_wr_in,
  output logic dev_ack_out
);
  logic [7:0] regs_q [256];
  logic [1:0] wait_q;
  logic slow_q;
  logic rot_on;
  logic fast_on;
  logic [8:0] stride;
  //////////////////////////////////////////////////////////////////////////
  // Enable low is landscape; the select bit only counts when enabled
  assign rot_on = regs_q[8'h1b][7];
  assign fast_on = rot_on & regs_q[8'h1b][6];
  // Stride code zero stands for 256 bytes
  assign stride = (regs_q[8'h1c] == 8'h00) ? 9'h100 : {1'b0, regs_q[8'h1c]};
  // Ack alternates between prompt and slow replies
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dev_ack_out <= 1'b0;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
    end else if (!dev_wr_in) begin
      dev_ack_out <= 1'b0;
      wait_q <= slow_q ? 2'h3 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (!dev_ack_out) begin
      dev_ack_out <= 1'b1;
      regs_q[dev_addr_in] <= dev_data_in;
      slow_q <= !slow_q;
    end
  end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rot_host_pkg::*;
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dwr, dack;
  logic [7:0] awaddr, araddr, daddr, ddata;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int fails, checked, seed;
  logic [9:0] w;
  logic [16:0] b;
  logic [3:0] ws;
  //////////////////////////////////////////////////////////////////////////
  rot_host_ctrl u_rot_host_ctrl (.core_clk_in(clk), .arst_n_in(arst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .dev_addr_out(daddr), .dev_data_out(ddata),
    .dev_wr_out(dwr), .dev_ack_in(dack));
  dev_model u_dev_model (.core_clk_in(clk), .arst_n_in(arst_n),
    .dev_addr_in(daddr), .dev_data_in(ddata), .dev_wr_in(dwr),
    .dev_ack_out(dack));
  //////////////////////////////////////////////////////////////////////////
  // Bus tasks; each starts just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Issue a command and poll busy until the device writes finish
  task automatic cmd(input logic [31:0] c);
    wr(OFS_CMD, c);
    repeat (4) @(posedge clk);
    do begin
      rd(OFS_STAT);
    end while (d[STAT_BUSY_BIT] !== 1'b0);
  endtask
  function automatic logic [7:0] vcode(input logic [9:0] wd);
    logic [9:0] v;
    v = 10'h1;
    while (v < wd) v = v << 1;
    return v[7:0];
  endfunction
  function automatic logic [16:0] dstart();
    return {u_dev_model.regs_q[8'h10][0], u_dev_model.regs_q[8'h0d],
      u_dev_model.regs_q[8'h0c]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, fails, checked} = '0;
    ws = 4'hf;
    seed = 32'h7a530698;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_STAT);
    chk("status", 32'h0, d);
    chk("rd resp ok", RESP_OKAY, r);
    // Default variant, 240 byte lines, virtual width 256
    wr(OFS_GEOM, 32'h014000f0);
    wr(OFS_BASE, 32'h100);
    wr(OFS_CLK, 32'd20000);
    wr(OFS_CTRL, 32'h12);
    chk("wr resp ok", RESP_OKAY, r);
    cmd(32'h1);
    chk("stride", 8'h00, u_dev_model.regs_q[8'h1c]);
    chk("start", 17'h1ef, dstart());
    chk("mode", 8'h81, u_dev_model.regs_q[8'h1b]);
    chk("stride bytes", 9'h100, u_dev_model.stride);
    cmd(32'h2);
    chk("pan right", 17'h1f0, dstart());
    cmd(32'h4);
    chk("pan down", 17'h3f0, dstart());
    rd(OFS_STAT);
    chk("stat", 32'h3f004, d);
    $display("test pow2 done");
    // Too large for the default variant: 160 bytes, 480 lines
    wr(OFS_GEOM, 32'h01e000a0);
    cmd(32'h1);
    chk("stride", 8'ha0, u_dev_model.regs_q[8'h1c]);
    chk("mode", 8'hc1, u_dev_model.regs_q[8'h1b]);
    chk("fast on", 1'b1, u_dev_model.fast_on);
    cmd(32'h4);
    chk("pan down", 17'h23f, dstart());
    $display("test fast done");
    wr(OFS_CTRL, 32'h102);
    rd(OFS_STAT);
    chk("split err", 32'h4, {28'h0, d[7:4]});
    wr(OFS_STAT, 32'hf0);
    wr(OFS_CLK, 32'd30000);
    cmd(32'h1);
    rd(OFS_STAT);
    chk("clk err", 32'h2, {28'h0, d[7:4]});
    chk("mode kept", 8'hc1, u_dev_model.regs_q[8'h1b]);
    wr(OFS_STAT, 32'hf0);
    wr(OFS_CLK, 32'd25000);
    wr(OFS_CTRL, 32'h34);
    cmd(32'h1);
    chk("landscape", 8'h00, u_dev_model.regs_q[8'h1b]);
    chk("rot on", 1'b0, u_dev_model.rot_on);
    wr(8'h40, 32'h1);
    chk("wr resp", RESP_SLVERR, r);
    rd(8'h40);
    chk("rd resp", RESP_SLVERR, r);
    // Byte strobe: only lane 1 of the base word changes
    ws <= 4'h2;
    wr(OFS_BASE, 32'hffffffff);
    ws <= 4'hf;
    rd(OFS_BASE);
    chk("strobe", 32'hff00, d);
    $display("test errors done");
    // Random widths and bases in the default variant
    repeat (6) begin
      w = 10'($unsigned($random(seed)) % 255 + 1);
      b = 17'($unsigned($random(seed)) % 65536);
      wr(OFS_GEOM, {16'h10, 6'h0, w});
      wr(OFS_BASE, {15'h0, b});
      wr(OFS_CTRL, {26'h0, 2'(seed), 4'h2});
      cmd(32'h1);
      chk("stride", vcode(w), u_dev_model.regs_q[8'h1c]);
      chk("start", b + w - 1, dstart());
      chk("mode", {6'h20, 2'(seed)}, u_dev_model.regs_q[8'h1b]);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule

// ### src/dev_reg_writer.sv
`timescale 1ns/1ns
module dev_reg_writer (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic req_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  output logic ready_out,
  output logic done_out,
  output logic [7:0] dev_addr_out,
  output logic [7:0] dev_data_out,
  output logic dev_wr_out,
  input wire logic dev_ack_in
);
  import rot_host_pkg::*;
  rot_host_pkg::wr_state_t state_q, state_d;
  logic ack_meta_q, ack_q;
  logic [7:0] addr_q, data_q;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge pin synchroniser
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_meta_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      ack_meta_q <= dev_ack_in;
      ack_q <= ack_meta_q;
    end
  end

  // Four-phase strobe: hold until acked, then wait for ack release
  assign take = (state_q == WR_IDLE) && req_in;
  always_comb begin
    state_d = state_q;
    case (state_q)
      WR_IDLE: if (req_in) state_d = WR_HOLD;
      WR_HOLD: if (ack_q) state_d = WR_REL;
      WR_REL: if (!ack_q) state_d = WR_IDLE;
      default: state_d = WR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= WR_IDLE;
      addr_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        addr_q <= addr_in;
        data_q <= data_in;
      end
    end
  end

  assign ready_out = (state_q == WR_IDLE);
  assign done_out = (state_q == WR_REL) && !ack_q;
  assign dev_wr_out = (state_q == WR_HOLD);
  assign dev_addr_out = addr_q;
  assign dev_data_out = data_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  strobe_hold_a: assert property (
    dev_wr_out && !ack_q |=> dev_wr_out && $stable(dev_addr_out))
    else $error("strobe dropped before acknowledge");
endmodule

// ### src/rot_host_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Pow2 variant needs a power-of-two virtual width, e.g. 256 bytes.
// - Prefer pow2 variant whenever the virtual image fits the buffer and the fast bit is clear.
// - Pow2 variant needs memory clock at least the pixel clock.
// - Fast variant needs memory clock at least twice the pixel clock.
// - Input clock at most 25 MHz, so fast pixel clock at most 12.5 MHz.
// - Start address is corner A plus line width in bytes minus one.
// - Pow2 stride is the virtual width; 256 bytes is coded as zero.
// - Fast variant stride is the real image width in bytes.
// - Adding one to start address pans one byte horizontally.
// - Pow2 vertical pan adds twice the stride, two lines; no single line.
// - Fast vertical pan adds the stride, moving exactly one line.
module rot_host_ctrl (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [7:0] dev_addr_out,
  output logic [7:0] dev_data_out,
  output logic dev_wr_out,
  input wire logic dev_ack_in
);
  import rot_host_pkg::*;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Smallest power of two not below a byte count
  function automatic logic [10:0] pow2_ceil(input logic [9:0] v);
    logic [10:0] p;
    p = 11'h001;
    for (int i = 0; i < 10; i++) begin
      if (p < {1'b0, v}) p = {p[9:0], 1'b0};
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic aw_have_q, w_have_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic wr_fire, aw_take, w_take, wr_mapped;

  assign s_axi_awready_out = !aw_have_q && !bvalid_q;
  assign s_axi_wready_out = !w_have_q && !bvalid_q;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_mapped = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_GEOM) ||
                     (awaddr_q == OFS_BASE) || (awaddr_q == OFS_CMD) ||
                     (awaddr_q == OFS_CLK) || (awaddr_q == OFS_STAT);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible configuration
  logic [31:0] ctrl_q, geom_q, base_q, clk_q;
  logic [3:0] err_q, err_set;
  logic busy;
  logic wr_ctrl, wr_cmd, wr_stat;
  logic [31:0] ctrl_new, cmd_word;
  logic split_refused;

  assign wr_ctrl = wr_fire && (awaddr_q == OFS_CTRL);
  assign wr_cmd = wr_fire && (awaddr_q == OFS_CMD);
  assign wr_stat = wr_fire && (awaddr_q == OFS_STAT);
  assign ctrl_new = merge(ctrl_q, wdata_q, wstrb_q);
  assign cmd_word = merge(32'h00000000, wdata_q, wstrb_q);
  // Split screen and rotation never stand together
  assign split_refused = wr_ctrl && ctrl_new[CTRL_SPLIT_BIT] &&
                         ctrl_new[CTRL_ROT_BIT];

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= 32'h00000000;
      geom_q <= 32'h00000000;
      base_q <= 32'h00000000;
      clk_q <= 32'h00000000;
    end else if (wr_fire) begin
      if (awaddr_q == OFS_CTRL && !split_refused) ctrl_q <= ctrl_new;
      if (awaddr_q == OFS_GEOM) geom_q <= merge(geom_q, wdata_q, wstrb_q);
      if (awaddr_q == OFS_BASE) base_q <= merge(base_q, wdata_q, wstrb_q);
      if (awaddr_q == OFS_CLK) clk_q <= merge(clk_q, wdata_q, wstrb_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Variant choice and address arithmetic
  logic [9:0] line_bytes, rows;
  logic [10:0] virt_w;
  logic [20:0] pow2_size, fast_size;
  logic pow2_fits, fast_fits, use_fast, rot_req, clk_bad, width_bad;
  logic [16:0] start_calc;
  logic [7:0] stride_calc;
  logic [16:0] pan_calc;
  logic apply_go, apply_ok, pan_r_ok, pan_d_ok;
  logic [3:0] apply_err;

  assign line_bytes = geom_q[9:0];
  assign rows = geom_q[GEOM_ROWS_LO +: 10];
  assign rot_req = ctrl_q[CTRL_ROT_BIT];
  // Rotated image width rounded up to a power of two
  assign virt_w = pow2_ceil(line_bytes);
  assign pow2_size = 21'(virt_w) * 21'(rows);
  assign fast_size = 21'(line_bytes) * 21'(rows);
  assign pow2_fits = (virt_w <= STRIDE_MAX) && (pow2_size <= BUF_BYTES);
  assign fast_fits = ({1'b0, line_bytes} <= STRIDE_MAX) &&
                     (fast_size <= BUF_BYTES);
  // Low-power variant whenever it fits, unless software forces fast
  assign use_fast = ctrl_q[CTRL_FAST_BIT] || !pow2_fits;
  // Input clock limit also caps the fast pixel clock at half of it
  assign clk_bad = rot_req && (clk_q[15:0] > CLK_MAX_KHZ);
  assign width_bad = rot_req && (line_bytes == 10'h000);
  // Refresh begins at corner B, the far end of corner A's line
  assign start_calc = base_q[16:0] + 17'(line_bytes) - 17'h00001;
  // Stride: 256 wraps to zero in the byte field
  assign stride_calc = use_fast ? line_bytes[7:0] : virt_w[7:0];
  // Vertical pan step: two lines in pow2, one line in fast
  assign pan_calc = use_fast ? 17'(line_bytes) : 17'({virt_w, 1'b0});

  assign apply_err[ERR_FIT] = rot_req && !width_bad &&
                              (use_fast ? !fast_fits : 1'b0);
  assign apply_err[ERR_CLK] = clk_bad;
  assign apply_err[ERR_SPLIT] = rot_req && ctrl_q[CTRL_SPLIT_BIT];
  assign apply_err[ERR_WIDTH] = width_bad;
  assign apply_go = wr_cmd && cmd_word[CMD_APPLY_BIT] && !busy;
  assign apply_ok = apply_go && (apply_err == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Active settings, start address and panning
  logic act_rot_q, act_fast_q;
  logic [16:0] start_q, pan_step_q;
  logic [7:0] stride_q;
  logic [1:0] sel_q;
  logic [2:0] step_q, last_q;

  assign pan_r_ok = wr_cmd && cmd_word[CMD_PAN_R_BIT] && !busy &&
                    !cmd_word[CMD_APPLY_BIT] && act_rot_q;
  assign pan_d_ok = wr_cmd && cmd_word[CMD_PAN_D_BIT] && !busy &&
                    !cmd_word[CMD_APPLY_BIT] && !pan_r_ok && act_rot_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_rot_q <= 1'b0;
      act_fast_q <= 1'b0;
      start_q <= 17'h00000;
      pan_step_q <= 17'h00000;
      stride_q <= 8'h00;
      sel_q <= 2'h0;
    end else if (apply_ok) begin
      act_rot_q <= rot_req;
      act_fast_q <= rot_req && use_fast;
      start_q <= start_calc;
      pan_step_q <= pan_calc;
      stride_q <= stride_calc;
      sel_q <= ctrl_q[CTRL_SEL_LO +: 2];
    end else if (pan_r_ok) begin
      start_q <= start_q + 17'h00001;
    end else if (pan_d_ok) begin
      start_q <= start_q + pan_step_q;
    end
  end

  // Sticky errors; a new error wins over a same-cycle clear
  assign err_set = (apply_go ? apply_err : 4'h0) |
                   {1'b0, split_refused, 2'b00};
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_q & ~(wr_stat ? wdata_q[STAT_ERR_LO +: 4] : 4'h0)) |
               err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device write sequencer
  seq_state_t seq_q, seq_d;
  logic wr_req, wr_ready, wr_done;
  logic [7:0] step_addr, step_data, mode_byte;
  logic [2:0] first_step;

  // Mode byte: enable, variant select, reserved zero, clock select
  assign mode_byte = {act_rot_q, act_rot_q && act_fast_q, 3'b000, 1'b0,
                      act_rot_q ? sel_q : 2'h0};
  // Only orientation registers are written; look-up and inversion stay put
  assign step_addr = (step_q == STEP_STRIDE) ? DEV_STRIDE :
                     (step_q == STEP_LO) ? DEV_START_LO :
                     (step_q == STEP_MID) ? DEV_START_MID :
                     (step_q == STEP_HI) ? DEV_START_HI : DEV_MODE;
  assign step_data = (step_q == STEP_STRIDE) ? stride_q :
                     (step_q == STEP_LO) ? start_q[7:0] :
                     (step_q == STEP_MID) ? start_q[15:8] :
                     (step_q == STEP_HI) ? {7'h00, start_q[16]} : mode_byte;
  assign first_step = (apply_ok && !rot_req) ? STEP_MODE :
                      apply_ok ? STEP_STRIDE : STEP_LO;
  assign busy = (seq_q != SEQ_IDLE);
  assign wr_req = (seq_q == SEQ_ISSUE);

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_IDLE: if (apply_ok || pan_r_ok || pan_d_ok) seq_d = SEQ_ISSUE;
      SEQ_ISSUE: if (wr_ready) seq_d = SEQ_WAIT;
      SEQ_WAIT: if (wr_done) seq_d = (step_q == last_q) ? SEQ_IDLE
                                                         : SEQ_ISSUE;
      default: seq_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_q <= SEQ_IDLE;
      step_q <= STEP_STRIDE;
      last_q <= STEP_MODE;
    end else begin
      seq_q <= seq_d;
      if (seq_q == SEQ_IDLE) begin
        step_q <= first_step;
        last_q <= apply_ok ? STEP_MODE : STEP_HI;
      end else if (seq_q == SEQ_WAIT && wr_done && step_q != last_q) begin
        step_q <= step_q + 3'h1;
      end
    end
  end

  dev_reg_writer u_writer (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .req_in(wr_req),
    .addr_in(step_addr),
    .data_in(step_data),
    .ready_out(wr_ready),
    .done_out(wr_done),
    .dev_addr_out(dev_addr_out),
    .dev_data_out(dev_data_out),
    .dev_wr_out(dev_wr_out),
    .dev_ack_in(dev_ack_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q, rd_word, stat_word;
  logic [1:0] rresp_q;
  logic rd_mapped, ar_take;
  logic [7:0] rd_addr;

  assign rd_addr = {s_axi_araddr_in[7:2], 2'b00};
  assign s_axi_arready_out = !rvalid_q;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign stat_word = {7'h00, start_q, err_q, 1'b0, act_rot_q, act_fast_q,
                      busy};
  assign rd_mapped = (rd_addr == OFS_CTRL) || (rd_addr == OFS_GEOM) ||
                     (rd_addr == OFS_BASE) || (rd_addr == OFS_CMD) ||
                     (rd_addr == OFS_CLK) || (rd_addr == OFS_STAT);
  assign rd_word = (rd_addr == OFS_CTRL) ? ctrl_q :
                   (rd_addr == OFS_GEOM) ? geom_q :
                   (rd_addr == OFS_BASE) ? base_q :
                   (rd_addr == OFS_CLK) ? clk_q :
                   (rd_addr == OFS_STAT) ? stat_word : 32'h00000000;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  start_addr_a: assert property (
    apply_ok |=> start_q == $past(start_calc))
    else $error("start address not corner A plus width minus one");
  stride_wrap_a: assert property (
    apply_ok && rot_req && !use_fast && virt_w == STRIDE_MAX
    |=> stride_q == 8'h00)
    else $error("256 byte stride not coded as zero");
  pow2_width_a: assert property (
    apply_ok && rot_req && !use_fast
    |=> (stride_q & (stride_q - 8'h01)) == 8'h00)
    else $error("pow2 stride is not a power of two");
  prefer_pow2_a: assert property (
    apply_ok && rot_req && pow2_fits && !ctrl_q[CTRL_FAST_BIT]
    |=> !act_fast_q)
    else $error("fast variant chosen though pow2 fits");
  pan_byte_a: assert property (
    pan_r_ok |=> start_q == $past(start_q) + 17'h00001)
    else $error("horizontal pan not one byte");
  pan_two_a: assert property (
    pan_d_ok && !act_fast_q
    |=> start_q == $past(start_q) + {5'h00, stride_q == 8'h00,
                                     stride_q, 1'b0} ||
        !act_rot_q)
    else $error("pow2 vertical pan not two strides");
  pan_line_a: assert property (
    pan_d_ok && act_fast_q |=> start_q == $past(start_q) + pan_step_q)
    else $error("fast vertical pan not one stride");
  mode_byte_a: assert property (
    dev_wr_out && dev_addr_out == DEV_MODE && act_rot_q
    |-> dev_data_out[MODE_EN_BIT -: 2] == {1'b1, act_fast_q})
    else $error("mode byte does not match variant");
  landscape_a: assert property (
    dev_wr_out && dev_addr_out == DEV_MODE && !act_rot_q
    |-> dev_data_out[MODE_EN_BIT] == 1'b0)
    else $error("landscape write sets rotation enable");
  split_block_a: assert property (
    split_refused |=> err_q[ERR_SPLIT] && ctrl_q == $past(ctrl_q))
    else $error("split screen accepted during rotation");
  clk_limit_a: assert property (
    apply_go && clk_bad |=> err_q[ERR_CLK] && !busy)
    else $error("fast input clock not refused");
  write_resp_a: assert property (
    wr_fire |=> bvalid_q [*1] ##0 !aw_have_q)
    else $error("write response missing");

  apply_pow2_c: cover property (apply_ok && rot_req && !use_fast);
  apply_fast_c: cover property (apply_ok && rot_req && use_fast);
  pan_down_c: cover property (pan_d_ok ##[1:200] !busy);
  split_ref_c: cover property (split_refused);
endmodule

// ### src/rot_host_pkg.sv
package rot_host_pkg;
  // Controller register offsets on the AXI4-Lite side
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GEOM = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_CLK = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Control register fields
  localparam int CTRL_ROT_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_SEL_LO = 4;
  localparam int CTRL_SPLIT_BIT = 8;
  // Command register fields, write-only pulses
  localparam int CMD_APPLY_BIT = 0;
  localparam int CMD_PAN_R_BIT = 1;
  localparam int CMD_PAN_D_BIT = 2;
  // Geometry fields
  localparam int GEOM_ROWS_LO = 16;
  // Error bits
  localparam int ERR_FIT = 0;
  localparam int ERR_CLK = 1;
  localparam int ERR_SPLIT = 2;
  localparam int ERR_WIDTH = 3;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAST_BIT = 1;
  localparam int STAT_ROT_BIT = 2;
  localparam int STAT_ERR_LO = 4;
  localparam int STAT_START_LO = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Device register indices
  localparam logic [7:0] DEV_START_LO = 8'h0c;
  localparam logic [7:0] DEV_START_MID = 8'h0d;
  localparam logic [7:0] DEV_START_HI = 8'h10;
  localparam logic [7:0] DEV_MODE = 8'h1b;
  localparam logic [7:0] DEV_STRIDE = 8'h1c;
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_SEL_BIT = 6;
  // Device limits
  localparam logic [20:0] BUF_BYTES = 21'h014000;
  localparam logic [10:0] STRIDE_MAX = 11'h100;
  localparam logic [15:0] CLK_MAX_KHZ = 16'h61a8;
  // Sequence steps
  localparam logic [2:0] STEP_STRIDE = 3'h0;
  localparam logic [2:0] STEP_LO = 3'h1;
  localparam logic [2:0] STEP_MID = 3'h2;
  localparam logic [2:0] STEP_HI = 3'h3;
  localparam logic [2:0] STEP_MODE = 3'h4;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HOLD = 2'b01,
    WR_REL = 2'b10
  } wr_state_t;
endpackage
